/* File: core/fbm_core.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// - unsupported function code answers with exception 01h.
// - address outside the accepted references answers with exception 02h.
// - quantity beyond what one transaction handles answers with exception 03h.
// - exception 03h never reports an out-of-range written value.
// - unrecoverable execution error answers 04h and records error details.
// - coils are read/write single bits, each one control-word bit.
// - coil numbers start at one and equal the wire address.
// - standard profile: coils 1-16 drive control-word bits; 17-32 reserved.
// - native profile: coils map to their listed control bits; others reserved.
// - coil 33 drives relay-output control word bit 0 in both profiles.
// - discrete inputs are read-only status bits; writes are not accepted.
// - standard profile: discrete inputs 0-14 report status bits; 15-31 reserved.
// - native profile: discrete inputs report their listed status bits.
// - discrete inputs 32-35 report delayed digital inputs one to four.
// - discrete input 36 reports bit 4 of bidirectional-pin delayed status.
// - a query finishing without error clears stored error information.
// - device failure captures failing function code and failed register.
module fbm_core (
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  input  wire fbm_pkg::fbm_profile_t profile_i,
  input  wire logic                  query_valid_i,
  input  wire logic [7:0]            query_fc_i,
  input  wire logic [15:0]           query_addr_i,
  input  wire logic [15:0]           query_qty_i,
  input  wire logic                  wr_bit_i,
  input  wire logic                  exec_fail_i,
  input  wire logic [31:0]           status_word_i,
  input  wire logic [3:0]            di_delayed_i,
  input  wire logic [4:0]            dio_delayed_i,
  output logic                       reply_valid_o,
  output logic [7:0]                 reply_fc_o,
  output logic [7:0]                 reply_exc_o,
  output logic                       reply_bit_o,
  output logic [31:0]                ctl_word_o,
  output logic [15:0]                relay_word_o,
  output logic [7:0]                 err_fc_o,
  output logic [15:0]                err_reg_o
);
  import fbm_pkg::*;

  // ----------------------------------------------------------------
  // reference decode
  // ----------------------------------------------------------------
  fbm_map_if map_bus ();

  assign map_bus.profile  = profile_i;
  assign map_bus.is_di    = (query_fc_i == FC_RD_DI);
  assign map_bus.ref_addr = query_addr_i;

  fbm_ref_map u_map (
    .m (map_bus.map)
  );

  // ----------------------------------------------------------------
  // exception selection
  // ----------------------------------------------------------------
  fbm_state_t  state_reg;
  fbm_state_t  state_next;
  logic        fc_ok;
  logic        is_write;
  logic        qty_bad;
  logic [7:0]  exc_next;
  logic [36:0] coil_view;
  logic [36:0] di_view;
  logic        rd_bit;
  logic [4:0]  idx_lo;

  assign is_write = (query_fc_i == FC_WR_COIL) || (query_fc_i == FC_WR_COILS);
  // discrete inputs have no write function, so a write can never reach them
  assign fc_ok    = is_write || (query_fc_i == FC_RD_COIL)
                    || (query_fc_i == FC_RD_DI);
  // single coil write carries no quantity field
  assign qty_bad  = (query_fc_i != FC_WR_COIL)
                    && ((query_qty_i == 16'h0000) || (query_qty_i > MAX_QTY));
  assign idx_lo   = map_bus.idx[4:0];

  always_comb begin
    // order: function, quantity, address, then execution
    if (!fc_ok) begin
      exc_next = EXC_FUNC;
    end else if (qty_bad) begin
      exc_next = EXC_QTY;
    end else if (!map_bus.hit) begin
      exc_next = EXC_ADDR;
    end else if (exec_fail_i) begin
      exc_next = EXC_FAIL;
    end else begin
      exc_next = EXC_NONE;
    end
  end

  assign coil_view = {4'h0, relay_word_o[0], ctl_word_o};
  assign di_view   = {dio_delayed_i[DIO_BIT], di_delayed_i, status_word_i};
  assign rd_bit    = (query_fc_i == FC_RD_DI) ? di_view[map_bus.idx] : coil_view[map_bus.idx];

  // ----------------------------------------------------------------
  // reply sequencing
  // ----------------------------------------------------------------
  always_comb begin
    unique case (state_reg)
      ST_IDLE:  state_next = query_valid_i ? ST_REPLY : ST_IDLE;
      ST_REPLY: state_next = query_valid_i ? ST_REPLY : ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reply_valid_o = state_reg[1];

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reply_fc_o  <= 8'h00;
      reply_exc_o <= EXC_NONE;
      reply_bit_o <= 1'b0;
    end else if (query_valid_i) begin
      reply_fc_o  <= (exc_next != EXC_NONE) ? (query_fc_i | FC_EXC_FLAG) : query_fc_i;
      reply_exc_o <= exc_next;
      reply_bit_o <= (exc_next == EXC_NONE) && !is_write && rd_bit;
    end
  end

  // ----------------------------------------------------------------
  // control and relay words
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctl_word_o   <= CTL_WORD_RST;
      relay_word_o <= RELAY_WORD_RST;
    end else if (query_valid_i && is_write && exc_next == EXC_NONE) begin
      if (map_bus.idx == IDX_RELAY) begin
        relay_word_o[0] <= wr_bit_i;
      end else begin
        ctl_word_o[idx_lo] <= wr_bit_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // error record
  // ----------------------------------------------------------------
  // other exceptions leave the record alone: it describes the last failure
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      err_fc_o  <= 8'h00;
      err_reg_o <= 16'h0000;
    end else if (query_valid_i && exc_next == EXC_FAIL) begin
      err_fc_o  <= query_fc_i;
      err_reg_o <= query_addr_i;
    end else if (query_valid_i && exc_next == EXC_NONE) begin
      err_fc_o  <= 8'h00;
      err_reg_o <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence q_good_s;
    query_valid_i && fc_ok && !qty_bad && map_bus.hit;
  endsequence

  sequence q_clean_s;
    q_good_s ##0 !exec_fail_i;
  endsequence

  bad_func_a: assert property (query_valid_i && !fc_ok |=>
    reply_valid_o && reply_exc_o == EXC_FUNC && reply_fc_o == ($past(query_fc_i) | FC_EXC_FLAG))
    else $error("bad function not answered 01h");
  bad_addr_a: assert property (query_valid_i && fc_ok && !qty_bad && !map_bus.hit |=>
    reply_valid_o && reply_exc_o == EXC_ADDR)
    else $error("bad address not answered 02h");
  bad_qty_a: assert property (query_valid_i && fc_ok && qty_bad |=> reply_exc_o == EXC_QTY)
    else $error("bad quantity not answered 03h");
  qty_only_a: assert property (reply_valid_o && reply_exc_o == EXC_QTY |-> $past(qty_bad))
    else $error("03h given without excessive quantity");
  dev_fail_a: assert property (q_good_s ##0 exec_fail_i |=>
    reply_exc_o == EXC_FAIL && err_fc_o == $past(query_fc_i) && err_reg_o == $past(query_addr_i))
    else $error("device failure not reported or recorded");
  exc_echo_a: assert property (reply_valid_o && reply_exc_o != EXC_NONE |-> reply_fc_o[7])
    else $error("exception reply lacks flagged function code");
  err_clear_a: assert property (q_clean_s |=> err_fc_o == 8'h00 && err_reg_o == 16'h0000)
    else $error("error record not cleared on success");
  coil_write_a: assert property (q_clean_s ##0 is_write && map_bus.idx <= IDX_WORD_TOP |=>
    ctl_word_o[$past(idx_lo)] == $past(wr_bit_i))
    else $error("coil write lost");
  relay_a: assert property (q_clean_s ##0 is_write && query_addr_i == COIL_RELAY |=>
    relay_word_o[0] == $past(wr_bit_i) && $stable(ctl_word_o))
    else $error("relay coil write wrong");
  di_ro_a: assert property (query_valid_i && query_fc_i == FC_RD_DI |=>
    $stable(ctl_word_o) && $stable(relay_word_o))
    else $error("discrete input access changed control state");
  di_delay_a: assert property (q_clean_s ##0 query_fc_i == FC_RD_DI && query_addr_i == DI_DIO |=>
    reply_bit_o == $past(dio_delayed_i[DIO_BIT]))
    else $error("pin delayed status not reported");

  // reads of the status word and of the four delayed inputs
  sequence q_status_s;
    q_clean_s ##0 query_fc_i == FC_RD_DI && query_addr_i <= 16'(IDX_WORD_TOP);
  endsequence

  sequence q_delay_s;
    q_clean_s ##0 query_fc_i == FC_RD_DI && query_addr_i[15:2] == 14'h0008;
  endsequence

  reply_pulse_a: assert property (query_valid_i |=> reply_valid_o)
    else $error("query not answered in the next cycle");
  reply_drop_a: assert property (!query_valid_i |=> !reply_valid_o)
    else $error("reply strobe held without a query");
  status_read_a: assert property (q_status_s |=>
    reply_bit_o == $past(status_word_i[query_addr_i[4:0]]))
    else $error("status bit not reported");
  di_inputs_a: assert property (q_delay_s |=>
    reply_bit_o == $past(di_delayed_i[query_addr_i[1:0]]))
    else $error("delayed input not reported");
  coil_read_a: assert property (q_clean_s ##0 query_fc_i == FC_RD_COIL |=>
    reply_bit_o == $past(coil_view[map_bus.idx]))
    else $error("coil read value wrong");

endmodule // fbm_core

`default_nettype wire

/* File: core/fbm_pkg.sv */
package fbm_pkg;

  // ----------------------------------------------------------------
  // function codes handled by the bit-access server
  // ----------------------------------------------------------------
  localparam logic [7:0] FC_RD_COIL  = 8'h01;
  localparam logic [7:0] FC_RD_DI    = 8'h02;
  localparam logic [7:0] FC_WR_COIL  = 8'h05;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;

  // ----------------------------------------------------------------
  // exception codes
  // ----------------------------------------------------------------
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_QTY  = 8'h03;
  localparam logic [7:0] EXC_FAIL = 8'h04;

  // one reference per transaction
  localparam logic [15:0] MAX_QTY = 16'h0001;

  // ----------------------------------------------------------------
  // reference space
  // ----------------------------------------------------------------
  localparam logic [15:0] COIL_FIRST   = 16'h0001;
  localparam logic [15:0] COIL_RELAY   = 16'h0021;
  localparam logic [15:0] DI_DIO       = 16'h0024;
  localparam logic [5:0]  IDX_RELAY    = 6'h20;
  localparam logic [5:0]  IDX_WORD_TOP = 6'h1f;
  localparam int          DIO_BIT      = 4;

  // bit n set: reference index n carries a function in that profile
  localparam logic [31:0] STD_COIL_MASK = 32'h0000_ffff;
  localparam logic [31:0] NAT_COIL_MASK = 32'h03d3_3bf3;
  localparam logic [31:0] STD_DI_MASK   = 32'h0000_7fff;
  localparam logic [31:0] NAT_DI_MASK   = 32'h07c1_f39b;

  // reset values
  localparam logic [31:0] CTL_WORD_RST   = 32'h0000_0000;
  localparam logic [15:0] RELAY_WORD_RST = 16'h0000;

  typedef enum logic {
    FBM_STD    = 1'b0,
    FBM_NATIVE = 1'b1
  } fbm_profile_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_REPLY = 2'b10
  } fbm_state_t;

endpackage

/* File: core/fbm_map_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface fbm_map_if;
  import fbm_pkg::*;
  fbm_profile_t profile;
  logic         is_di;
  logic [15:0]  ref_addr;
  logic         hit;
  logic [5:0]   idx;

  modport core (output profile, output is_di, output ref_addr, input hit, input idx);
  modport map  (input profile, input is_di, input ref_addr, output hit, output idx);
endinterface

`default_nettype wire

/* File: core/fbm_ref_map.sv */
`timescale 1ns/1ps
`default_nettype none

module fbm_ref_map (
  fbm_map_if.map m
);
  import fbm_pkg::*;

  logic [31:0] mask;
  logic [15:0] word_idx;

  always_comb begin
    mask     = STD_COIL_MASK;
    word_idx = 16'h0000;
    m.hit    = 1'b0;
    m.idx    = 6'h00;
    if (m.is_di) begin
      mask     = (m.profile == FBM_NATIVE) ? NAT_DI_MASK : STD_DI_MASK;
      word_idx = m.ref_addr;
      // delayed digital inputs and the bidirectional pin, both profiles
      if (m.ref_addr >= 16'(IDX_RELAY) && m.ref_addr <= DI_DIO) begin
        m.hit = 1'b1;
        m.idx = m.ref_addr[5:0];
      end else if (m.ref_addr <= 16'(IDX_WORD_TOP)) begin
        m.hit = mask[word_idx[4:0]];
        m.idx = word_idx[5:0];
      end
    end else begin
      mask = (m.profile == FBM_NATIVE) ? NAT_COIL_MASK : STD_COIL_MASK;
      // wire address is the reference itself, coil n lands on bit n-1
      word_idx = m.ref_addr - COIL_FIRST;
      if (m.ref_addr == COIL_RELAY) begin
        m.hit = 1'b1;
        m.idx = IDX_RELAY;
      end else if (m.ref_addr >= COIL_FIRST && word_idx <= 16'(IDX_WORD_TOP)) begin
        m.hit = mask[word_idx[4:0]];
        m.idx = word_idx[5:0];
      end
    end
  end

endmodule // fbm_ref_map

`default_nettype wire

/* File: dv/fbm_client_model.sv */
`timescale 1ns/1ps
`default_nettype none

module fbm_client_model
  import fbm_pkg::*;
(
  input  wire logic                  mclk_i,
  output var  fbm_pkg::fbm_profile_t profile_o,
  output var  logic                  query_valid_o,
  output var  logic [7:0]            query_fc_o,
  output var  logic [15:0]           query_addr_o,
  output var  logic [15:0]           query_qty_o,
  output var  logic                  wr_bit_o,
  output var  logic                  exec_fail_o,
  output var  logic [31:0]           status_word_o,
  output var  logic [3:0]            di_delayed_o,
  output var  logic [4:0]            dio_delayed_o
);
  initial begin
    profile_o = FBM_STD;
    query_valid_o = 1'b0;
    {query_fc_o, query_addr_o, query_qty_o, wr_bit_o, exec_fail_o} = '0;
    {status_word_o, di_delayed_o, dio_delayed_o} = '0;
  end

  // profile travels with every query so each reference is read in its meaning
  task automatic send(input fbm_profile_t p, input logic [7:0] fc, input logic [15:0] a, q,
                      input logic w, f, input logic [31:0] sw, input logic [3:0] di,
                      input logic [4:0] dio);
    @(posedge mclk_i);
    profile_o <= p;
    query_valid_o <= 1'b1;
    {query_fc_o, query_addr_o, query_qty_o, wr_bit_o, exec_fail_o} <= {fc, a, q, w, f};
    {status_word_o, di_delayed_o, dio_delayed_o} <= {sw, di, dio};
    @(posedge mclk_i);
    // outside a query the function, address, quantity and fail lines carry the inverse of the last value; the rest hold it
    query_valid_o <= 1'b0;
    {query_fc_o, query_addr_o, query_qty_o, exec_fail_o} <= ~{fc, a, q, f};
    #1;
  endtask
endmodule // fbm_client_model

`default_nettype wire

/* File: dv/tb_fbm_core.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_fbm_core;
  import fbm_pkg::*;
  logic         mclk_i    = 1'b0;
  logic         sys_rst_i = 1'b1;
  fbm_profile_t prof;
  logic         qv, wb, fl, rv, rbit;
  logic [7:0]   qfc, rfc, rexc, efc, m_efc;
  logic [15:0]  qa, qq, relay, ereg, m_relay, m_ereg;
  logic [31:0]  sw, ctl, m_ctl, r;
  logic [3:0]   di;
  logic [4:0]   dio;
  logic [7:0]   fcs [8] = '{8'h01, 8'h02, 8'h05, 8'h0f, 8'h01, 8'h02, 8'h03, 8'h2b};
  int           n_errors    = 0;
  int           check_count = 0;
  integer       seed        = 69811;

  always #12.5 mclk_i = ~mclk_i;

  fbm_client_model u_fbm_client_model (.mclk_i(mclk_i), .profile_o(prof),
    .query_valid_o(qv), .query_fc_o(qfc), .query_addr_o(qa), .query_qty_o(qq),
    .wr_bit_o(wb), .exec_fail_o(fl), .status_word_o(sw), .di_delayed_o(di),
    .dio_delayed_o(dio));

  fbm_core u_fbm_core (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .profile_i(prof),
    .query_valid_i(qv), .query_fc_i(qfc), .query_addr_i(qa), .query_qty_i(qq),
    .wr_bit_i(wb), .exec_fail_i(fl), .status_word_i(sw), .di_delayed_i(di),
    .dio_delayed_i(dio), .reply_valid_o(rv), .reply_fc_o(rfc), .reply_exc_o(rexc),
    .reply_bit_o(rbit), .ctl_word_o(ctl), .relay_word_o(relay), .err_fc_o(efc),
    .err_reg_o(ereg));

  // ------------------------------------------------------------
  // expectation
  // ------------------------------------------------------------
  function automatic logic [7:0] exp_exc(input logic p, input logic [7:0] fc,
                                         input logic [15:0] a, q, input logic f);
    logic [31:0] cm;
    logic [31:0] dm;
    logic        ok;
    cm = p ? 32'h03d3_3bf3 : 32'h0000_ffff;
    dm = p ? 32'h07c1_f39b : 32'h0000_7fff;
    if (fc != 8'h01 && fc != 8'h02 && fc != 8'h05 && fc != 8'h0f) return 8'h01;
    if (fc != 8'h05 && q != 16'h0001) return 8'h03;
    if (fc == 8'h02) ok = (a >= 16'h0020 && a <= 16'h0024) || (a < 16'h0020 && dm[a]);
    else ok = a == 16'h0021 || (a != 16'h0000 && a <= 16'h0020 && cm[a - 16'h0001]);
    if (!ok) return 8'h02;
    return f ? 8'h04 : 8'h00;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic query(input logic p, input logic [7:0] fc, input logic [15:0] a, q,
                       input logic w, f);
    logic [31:0] s;
    logic [31:0] d;
    logic [7:0]  ex;
    logic        rd;
    s = $random(seed);
    d = $random(seed);
    ex = exp_exc(p, fc, a, q, f);
    rd = 1'b0;
    if (ex == 8'h00 && fc == 8'h01) rd = (a == 16'h0021) ? m_relay[0] : m_ctl[a - 16'h0001];
    if (ex == 8'h00 && fc == 8'h02) rd = a < 16'h0020 ? s[a] : a < 16'h0024 ? d[a - 16'h0020] : d[8];
    u_fbm_client_model.send(fbm_profile_t'(p), fc, a, q, w, f, s, d[3:0], d[8:4]);
    if (ex == 8'h00 && (fc == 8'h05 || fc == 8'h0f)) begin
      if (a == 16'h0021) m_relay[0] = w;
      else m_ctl[a - 16'h0001] = w;
    end
    if (ex == 8'h04) {m_efc, m_ereg} = {fc, a};
    if (ex == 8'h00) {m_efc, m_ereg} = '0;
    check("reply_valid", 32'(rv), 32'h1);
    check("reply_exc", 32'(rexc), 32'(ex));
    check("reply_fc", 32'(rfc), 32'(ex == 8'h00 ? fc : fc | 8'h80));
    check("reply_bit", 32'(rbit), 32'(rd));
    check("ctl_word", ctl, m_ctl);
    check("relay_word", 32'(relay), 32'(m_relay));
    check("err_fc", 32'(efc), 32'(m_efc));
    check("err_reg", 32'(ereg), 32'(m_ereg));
  endtask

  task automatic do_reset;
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    #1;
    {m_ctl, m_relay, m_efc, m_ereg} = '0;
    check("ctl_rst", ctl, 32'h0);
    check("relay_rst", 32'(relay), 32'h0);
    check("err_rst", {8'h0, efc, ereg}, 32'h0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    $display("test reset done");
    query(1'b0, 8'h05, 16'h0000, 16'h0000, 1'b1, 1'b0);
    query(1'b1, 8'h05, 16'h0021, 16'h0000, 1'b1, 1'b0);
    query(1'b0, 8'h01, 16'h0021, 16'h0001, 1'b0, 1'b0);
    query(1'b1, 8'h05, 16'h0003, 16'h0001, 1'b1, 1'b0);
    query(1'b0, 8'h0f, 16'h0003, 16'h0001, 1'b1, 1'b0);
    query(1'b0, 8'h01, 16'h0003, 16'h0000, 1'b0, 1'b0);
    query(1'b0, 8'h0f, 16'h0001, 16'h0002, 1'b1, 1'b0);
    query(1'b0, 8'h01, 16'h0003, 16'h0001, 1'b0, 1'b1);
    query(1'b0, 8'h03, 16'h0003, 16'h0001, 1'b0, 1'b1);
    query(1'b1, 8'h02, 16'h0024, 16'h0001, 1'b0, 1'b0);
    $display("test corners done");
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      query(r[16], fcs[r[2:0]], {10'h0, r[8:3]},
            r[11:9] == 3'h0 ? 16'h0000 : r[11:9] == 3'h7 ? 16'h0002 : 16'h0001,
            r[12], r[15:13] == 3'h0);
    end
    $display("test random done");
    do_reset();
    query(1'b1, 8'h01, 16'h0001, 16'h0001, 1'b0, 1'b0);
    $display("test second reset done");
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge mclk_i);
    n_errors++;
    tally_and_finish();
  end
endmodule // tb_fbm_core

`default_nettype wire
